//--- hdl/clk_tree_pkg.sv
package clk_tree_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_ROOT_SEL    = 8'h04;
  localparam logic [7:0] ADDR_DAC_COARSE  = 8'h0B;
  localparam logic [7:0] ADDR_DAC_FINE    = 8'h0C;
  localparam logic [7:0] ADDR_DAC_OSR_HI  = 8'h0D;
  localparam logic [7:0] ADDR_DAC_OSR_LO  = 8'h0E;
  localparam logic [7:0] ADDR_ADC_COARSE  = 8'h12;
  localparam logic [7:0] ADDR_ADC_FINE    = 8'h13;
  localparam logic [7:0] ADDR_ADC_OSR     = 8'h14;
  localparam logic [7:0] ADDR_CLKOUT_SEL  = 8'h19;
  localparam logic [7:0] ADDR_CLKOUT_DIV  = 8'h1A;
  localparam logic [7:0] ADDR_IFACE_CTRL  = 8'h1B;
  localparam logic [7:0] ADDR_BCLK_SEL    = 8'h1D;
  localparam logic [7:0] ADDR_BCLK_DIV    = 8'h1E;
  localparam logic [7:0] ADDR_ADC_STATUS  = 8'h24;
  localparam logic [7:0] ADDR_DAC_STATUS  = 8'h25;
  // ==========================================================
  // field positions
  localparam int POWER_BIT       = 7;
  localparam int BCLK_DRIVE_BIT  = 3;
  localparam int ADC_FLAG_BIT    = 6;
  localparam int DAC_LEFT_BIT    = 7;
  localparam int DAC_RIGHT_BIT   = 3;
  localparam logic [1:0] ROOT_SEL_PLL = 2'h3;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_DIV_ONE = 8'h01;
  localparam logic [7:0] RST_OSR_LO  = 8'h80;
  // ==========================================================
  // timing: modulator ticks spent in channel shutdown
  localparam logic [7:0] SHUTDOWN_MOD_TICKS = 8'h20;

  // zero field selects the largest ratio
  function automatic logic [10:0] div_ratio(input logic [9:0] field,
                                            input logic [10:0] span);
    div_ratio = (field == 10'h000) ? span : {1'b0, field};
  endfunction
endpackage

//--- hdl/clock_divider.sv
`timescale 1ns/1ps
module clock_divider #(
  parameter int W = 7
) (
  input  wire logic         clk,       // system clock
  input  wire logic         rst,       // sync reset
  input  wire logic         src_level, // source clock level
  input  wire logic         power,     // divider power bit
  input  wire logic [W-1:0] ratio,     // ratio field, 0 = 2**W
  output logic              run,       // divider running
  output logic              level,     // divided clock level
  output logic              tick       // one pulse per output rise
);
  typedef struct packed {
    logic         prev;
    logic [W-1:0] count;
    logic         run;
    logic         level;
    logic         tick;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;
  logic [10:0] n;
  logic [10:0] half;

  always_comb begin
    n = clk_tree_pkg::div_ratio(10'(ratio), 11'(1 << W));
    half = (n + 11'h001) >> 1;
    next_st = st;
    next_st.prev = src_level;
    if (src_level && !st.prev) begin
      // power only takes effect at a period boundary
      if (st.count == '0) begin
        next_st.run = power;
      end
      if (next_st.run) begin
        next_st.count = (11'(st.count) + 11'h001 >= n) ? '0
                        : W'(st.count + 1'b1);
      end else begin
        next_st.count = '0;
      end
      next_st.level = next_st.run && (11'(st.count) < half);
    end
    if (n == 11'h001) begin
      next_st.level = next_st.run && src_level;
    end
    next_st.tick = next_st.level && !st.level;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign run   = st.run;
  assign level = st.level;
  assign tick  = st.tick;

  // ==========================================================
  // checks
  a_div_static: assert property (@(posedge clk) disable iff (rst)
    !run |=> !level || run)
    else $error("stopped divider drives a clock");
  a_div_clean_stop: assert property (@(posedge clk) disable iff (rst)
    $fell(run) |-> !$past(level))
    else $error("divider stopped in high phase");
endmodule // clock_divider

//--- hdl/channel_power_seq.sv
`timescale 1ns/1ps
module channel_power_seq (
  input  wire logic clk,      // system clock
  input  wire logic rst,      // sync reset
  input  wire logic chan_on,  // channel power request
  input  wire logic mod_tick, // modulator clock rise
  output logic      flag      // 1 = channel powered
);
  typedef enum logic [2:0] {
    CH_OFF   = 3'b001,
    CH_ON    = 3'b010,
    CH_DRAIN = 3'b100
  } ch_state_t;

  typedef struct packed {
    ch_state_t  state;
    logic [7:0] count;
  } seq_state_t;

  seq_state_t st;
  seq_state_t next_st;

  always_comb begin
    next_st = st;
    unique case (st.state)
      CH_OFF: begin
        if (chan_on && mod_tick) begin
          next_st.state = CH_ON;
        end
      end
      CH_ON: begin
        if (!chan_on) begin
          next_st.state = CH_DRAIN;
          next_st.count = '0;
        end
      end
      CH_DRAIN: begin
        // shutdown advances only on modulator ticks
        if (chan_on) begin
          next_st.state = CH_ON;
        end else if (mod_tick) begin
          next_st.count = st.count + 8'h01;
          if (st.count + 8'h01 == clk_tree_pkg::SHUTDOWN_MOD_TICKS) begin
            next_st.state = CH_OFF;
          end
        end
      end
      default: next_st.state = CH_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{state: CH_OFF, count: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign flag = (st.state != CH_OFF);

  // ==========================================================
  // checks
  a_flag_holds: assert property (@(posedge clk) disable iff (rst)
    flag && !chan_on && !mod_tick |=> flag)
    else $error("power flag dropped without modulator clock");
  a_flag_rise: assert property (@(posedge clk) disable iff (rst)
    $rose(flag) |-> $past(chan_on) && $past(mod_tick))
    else $error("power flag rose without request");
  c_shutdown_done: cover property (@(posedge clk) disable iff (rst)
    $fell(flag));
endmodule // channel_power_seq

//--- hdl/codec_clock_tree.sv
`timescale 1ns/1ps
module codec_clock_tree (
  input  wire logic       clk,            // system clock, 250 MHz
  input  wire logic       rst,            // sync reset, active high
  input  wire logic [7:0] reg_addr,       // register address
  input  wire logic       reg_wr,         // register write strobe
  input  wire logic       reg_rd,         // register read strobe
  input  wire logic [7:0] reg_wdata,      // register write data
  output logic      [7:0] reg_rdata,      // read data, next cycle
  input  wire logic       mclk_pin,       // master clock pin level
  input  wire logic       bclk_pin_in,    // bit clock pin level
  input  wire logic       general_pin_one_pin_in,   // general pin one level
  input  wire logic       pll_clk,        // PLL output level
  input  wire logic       dac_left_on,    // left DAC channel power
  input  wire logic       dac_right_on,   // right DAC channel power
  input  wire logic       adc_on,         // ADC channel power
  input  wire logic       clkout_to_dout, // clock out on data-out pin
  output logic            bclk_pin_out,   // bit clock pin drive
  output logic            bclk_pin_oe,    // bit clock pin enable
  output logic            general_pin_one_pin_out,  // general pin one drive
  output logic            general_pin_one_pin_oe,   // general pin one enable
  output logic            dout_pin_out,   // data-out pin clock drive
  output logic            dout_pin_oe,    // data-out pin clock enable
  output logic            dac_modulator_clock,    // DAC modulator clock
  output logic            adc_modulator_clock,    // ADC modulator clock
  output logic            dac_fs_tick,    // DAC sample pulse
  output logic            adc_fs_tick     // ADC sample pulse
);
  // ==========================================================
  // register state
  typedef struct packed {
    logic [7:0] root_sel;
    logic [7:0] dac_n;
    logic [7:0] dac_m;
    logic [7:0] dac_oversample_high_hi;
    logic [7:0] dac_oversample_high_lo;
    logic [7:0] adc_n;
    logic [7:0] adc_m;
    logic [7:0] adc_oversample;
    logic [7:0] cout_sel;
    logic [7:0] cout_div;
    logic [7:0] iface;
    logic [7:0] bclk_sel;
    logic [7:0] bclk_div;
    logic [7:0] rdata;
  } tree_state_t;

  tree_state_t st;
  tree_state_t next_st;

  logic       root_level;
  logic       dac_clk;
  logic       dac_clk_tick;
  logic       dac_mod_tick;
  logic       dac_n_run;
  logic       dac_m_run;
  logic       adc_n_level;
  logic       adc_m_level;
  logic       adc_m_tick;
  logic       adc_n_run;
  logic       adc_m_run;
  logic       adc_clk;
  logic       adc_mod_tick;
  logic       bclk_level;
  logic       cout_level;
  logic       cout_run;
  logic       bclk_run;
  logic       dac_left_flag;
  logic       dac_right_flag;
  logic       adc_flag;
  logic [7:0] src_levels;
  logic [9:0] dac_oversample_high;

  // ==========================================================
  // register file
  always_comb begin
    next_st = st;
    if (reg_wr) begin
      unique case (reg_addr)
        clk_tree_pkg::ADDR_ROOT_SEL:   next_st.root_sel = reg_wdata;
        clk_tree_pkg::ADDR_DAC_COARSE: next_st.dac_n = reg_wdata;
        clk_tree_pkg::ADDR_DAC_FINE:   next_st.dac_m = reg_wdata;
        clk_tree_pkg::ADDR_DAC_OSR_HI: next_st.dac_oversample_high_hi = reg_wdata;
        clk_tree_pkg::ADDR_DAC_OSR_LO: next_st.dac_oversample_high_lo = reg_wdata;
        clk_tree_pkg::ADDR_ADC_COARSE: next_st.adc_n = reg_wdata;
        clk_tree_pkg::ADDR_ADC_FINE:   next_st.adc_m = reg_wdata;
        clk_tree_pkg::ADDR_ADC_OSR:    next_st.adc_oversample = reg_wdata;
        clk_tree_pkg::ADDR_CLKOUT_SEL: next_st.cout_sel = reg_wdata;
        clk_tree_pkg::ADDR_CLKOUT_DIV: next_st.cout_div = reg_wdata;
        clk_tree_pkg::ADDR_IFACE_CTRL: next_st.iface = reg_wdata;
        clk_tree_pkg::ADDR_BCLK_SEL:   next_st.bclk_sel = reg_wdata;
        clk_tree_pkg::ADDR_BCLK_DIV:   next_st.bclk_div = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        clk_tree_pkg::ADDR_ROOT_SEL:   next_st.rdata = st.root_sel;
        clk_tree_pkg::ADDR_DAC_COARSE: next_st.rdata = st.dac_n;
        clk_tree_pkg::ADDR_DAC_FINE:   next_st.rdata = st.dac_m;
        clk_tree_pkg::ADDR_DAC_OSR_HI: next_st.rdata = st.dac_oversample_high_hi;
        clk_tree_pkg::ADDR_DAC_OSR_LO: next_st.rdata = st.dac_oversample_high_lo;
        clk_tree_pkg::ADDR_ADC_COARSE: next_st.rdata = st.adc_n;
        clk_tree_pkg::ADDR_ADC_FINE:   next_st.rdata = st.adc_m;
        clk_tree_pkg::ADDR_ADC_OSR:    next_st.rdata = st.adc_oversample;
        clk_tree_pkg::ADDR_CLKOUT_SEL: next_st.rdata = st.cout_sel;
        clk_tree_pkg::ADDR_CLKOUT_DIV: next_st.rdata = st.cout_div;
        clk_tree_pkg::ADDR_IFACE_CTRL: next_st.rdata = st.iface;
        clk_tree_pkg::ADDR_BCLK_SEL:   next_st.rdata = st.bclk_sel;
        clk_tree_pkg::ADDR_BCLK_DIV:   next_st.rdata = st.bclk_div;
        clk_tree_pkg::ADDR_ADC_STATUS: begin
          next_st.rdata = 8'h00;
          next_st.rdata[clk_tree_pkg::ADC_FLAG_BIT] = adc_flag;
        end
        clk_tree_pkg::ADDR_DAC_STATUS: begin
          next_st.rdata = 8'h00;
          next_st.rdata[clk_tree_pkg::DAC_LEFT_BIT] = dac_left_flag;
          next_st.rdata[clk_tree_pkg::DAC_RIGHT_BIT] = dac_right_flag;
        end
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{root_sel: clk_tree_pkg::RST_ZERO,
              dac_n:    clk_tree_pkg::RST_DIV_ONE,
              dac_m:    clk_tree_pkg::RST_DIV_ONE,
              dac_oversample_high_hi:  clk_tree_pkg::RST_ZERO,
              dac_oversample_high_lo:  clk_tree_pkg::RST_OSR_LO,
              adc_n:    clk_tree_pkg::RST_DIV_ONE,
              adc_m:    clk_tree_pkg::RST_DIV_ONE,
              adc_oversample:     clk_tree_pkg::RST_OSR_LO,
              cout_sel: clk_tree_pkg::RST_ZERO,
              cout_div: clk_tree_pkg::RST_DIV_ONE,
              iface:    clk_tree_pkg::RST_ZERO,
              bclk_sel: clk_tree_pkg::RST_ZERO,
              bclk_div: clk_tree_pkg::RST_DIV_ONE,
              rdata:    clk_tree_pkg::RST_ZERO};
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;

  // ==========================================================
  // root clock and source map
  assign src_levels = {adc_modulator_clock, adc_clk, dac_modulator_clock, dac_clk,
                       pll_clk, general_pin_one_pin_in, bclk_pin_in, mclk_pin};
  assign root_level = src_levels[{1'b0, st.root_sel[1:0]}];
  assign dac_oversample_high       = {st.dac_oversample_high_hi[1:0], st.dac_oversample_high_lo};

  // ==========================================================
  // DAC chain: coarse, fine, oversampling
  clock_divider #(.W(7)) u_dac_coarse (
    .clk       (clk),
    .rst       (rst),
    .src_level (root_level),
    .power     (st.dac_n[clk_tree_pkg::POWER_BIT]),
    .ratio     (st.dac_n[6:0]),
    .run       (dac_n_run),
    .level     (dac_clk),
    .tick      (dac_clk_tick)
  );

  clock_divider #(.W(7)) u_dac_fine (
    .clk       (clk),
    .rst       (rst),
    .src_level (dac_clk),
    .power     (st.dac_m[clk_tree_pkg::POWER_BIT]),
    .ratio     (st.dac_m[6:0]),
    .run       (dac_m_run),
    .level     (dac_modulator_clock),
    .tick      (dac_mod_tick)
  );

  clock_divider #(.W(10)) u_dac_osr (
    .clk       (clk),
    .rst       (rst),
    .src_level (dac_modulator_clock),
    .power     (1'b1),
    .ratio     (dac_oversample_high),
    .run       (),
    .level     (),
    .tick      (dac_fs_tick)
  );

  // ==========================================================
  // ADC chain, falling back to DAC clocks when unpowered
  clock_divider #(.W(7)) u_adc_coarse (
    .clk       (clk),
    .rst       (rst),
    .src_level (root_level),
    .power     (st.adc_n[clk_tree_pkg::POWER_BIT]),
    .ratio     (st.adc_n[6:0]),
    .run       (adc_n_run),
    .level     (adc_n_level),
    .tick      ()
  );

  assign adc_clk = adc_n_run ? adc_n_level : dac_clk;

  clock_divider #(.W(7)) u_adc_fine (
    .clk       (clk),
    .rst       (rst),
    .src_level (adc_clk),
    .power     (st.adc_m[clk_tree_pkg::POWER_BIT]),
    .ratio     (st.adc_m[6:0]),
    .run       (adc_m_run),
    .level     (adc_m_level),
    .tick      (adc_m_tick)
  );

  // DAC dividers must stay on while they feed this path
  assign adc_modulator_clock  = adc_m_run ? adc_m_level : dac_modulator_clock;
  assign adc_mod_tick = adc_m_run ? adc_m_tick : dac_mod_tick;

  clock_divider #(.W(8)) u_adc_osr (
    .clk       (clk),
    .rst       (rst),
    .src_level (adc_modulator_clock),
    .power     (1'b1),
    .ratio     (st.adc_oversample),
    .run       (),
    .level     (),
    .tick      (adc_fs_tick)
  );

  // ==========================================================
  // bit clock and general clock outputs
  clock_divider #(.W(7)) u_bclk_div (
    .clk       (clk),
    .rst       (rst),
    .src_level (src_levels[{1'b1, st.bclk_sel[1:0]}]),
    .power     (st.iface[clk_tree_pkg::BCLK_DRIVE_BIT]),
    .ratio     (st.bclk_div[6:0]),
    .run       (bclk_run),
    .level     (bclk_level),
    .tick      ()
  );

  clock_divider #(.W(7)) u_clkout_div (
    .clk       (clk),
    .rst       (rst),
    .src_level (src_levels[st.cout_sel[2:0]]),
    .power     (st.cout_div[clk_tree_pkg::POWER_BIT]),
    .ratio     (st.cout_div[6:0]),
    .run       (cout_run),
    .level     (cout_level),
    .tick      ()
  );

  // keep driving until the divider has stopped low
  assign bclk_pin_oe   = st.iface[clk_tree_pkg::BCLK_DRIVE_BIT]
                         || bclk_run;
  assign bclk_pin_out  = bclk_level;
  assign general_pin_one_pin_oe  = cout_run && !clkout_to_dout;
  assign general_pin_one_pin_out = cout_level && !clkout_to_dout;
  assign dout_pin_oe   = cout_run && clkout_to_dout;
  assign dout_pin_out  = cout_level && clkout_to_dout;

  // ==========================================================
  // channel shutdown status
  channel_power_seq u_dac_left_seq (
    .clk      (clk),
    .rst      (rst),
    .chan_on  (dac_left_on),
    .mod_tick (dac_mod_tick),
    .flag     (dac_left_flag)
  );

  channel_power_seq u_dac_right_seq (
    .clk      (clk),
    .rst      (rst),
    .chan_on  (dac_right_on),
    .mod_tick (dac_mod_tick),
    .flag     (dac_right_flag)
  );

  channel_power_seq u_adc_seq (
    .clk      (clk),
    .rst      (rst),
    .chan_on  (adc_on),
    .mod_tick (adc_mod_tick),
    .flag     (adc_flag)
  );

  // ==========================================================
  // checks
  a_root_pll_pick: assert property (@(posedge clk) disable iff (rst)
    st.root_sel[1:0] == clk_tree_pkg::ROOT_SEL_PLL |-> root_level == pll_clk)
    else $error("root clock not taken from PLL");
  a_div_write: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == clk_tree_pkg::ADDR_DAC_COARSE
      |=> st.dac_n == $past(reg_wdata))
    else $error("coarse divider write lost power or ratio");
  a_status_read: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == clk_tree_pkg::ADDR_DAC_STATUS
      |=> reg_rdata[7] == $past(dac_left_flag)
          && reg_rdata[3] == $past(dac_right_flag))
    else $error("DAC status read wrong");
  a_adc_fallback: assert property (@(posedge clk) disable iff (rst)
    !adc_m_run |-> adc_modulator_clock == dac_modulator_clock)
    else $error("ADC modulator clock not from DAC");
  a_fs_from_mod: assert property (@(posedge clk) disable iff (rst)
    dac_fs_tick |-> $past(dac_mod_tick))
    else $error("DAC sample pulse without modulator edge");
  a_mod_from_coarse: assert property (@(posedge clk) disable iff (rst)
    dac_mod_tick |-> $past(dac_clk_tick) && dac_n_run)
    else $error("DAC modulator edge without coarse edge");
  a_bclk_quiet: assert property (@(posedge clk) disable iff (rst)
    !bclk_pin_oe ##1 !bclk_pin_oe |-> !bclk_pin_out)
    else $error("bit clock toggles while not driven");
  a_clkout_route: assert property (@(posedge clk) disable iff (rst)
    !(general_pin_one_pin_oe && dout_pin_oe) && (general_pin_one_pin_oe || !general_pin_one_pin_out)
      && (dout_pin_oe || !dout_pin_out))
    else $error("clock out driven on both pins");
  a_fine_quiet: assert property (@(posedge clk) disable iff (rst)
    !dac_m_run |-> !dac_modulator_clock && !dac_mod_tick)
    else $error("stopped fine divider drives a clock");
  c_dac_sample: cover property (@(posedge clk) disable iff (rst)
    dac_fs_tick);
  c_adc_sample: cover property (@(posedge clk) disable iff (rst)
    adc_fs_tick && !adc_n_run);
  c_bclk_out: cover property (@(posedge clk) disable iff (rst)
    bclk_pin_oe && $rose(bclk_pin_out));
endmodule // codec_clock_tree

//--- bench/codec_clock_divider_tree_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin fails++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module codec_clock_divider_tree_tb_top;
  logic       clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, clr = 0;
  logic       mclk_pin = 0, bclk_pin_in = 0, general_pin_one_pin_in = 0, pll_clk = 0;
  logic       dac_left_on = 0, dac_right_on = 0, adc_on = 0;
  logic       clkout_to_dout = 0, pb = 0, pg = 0, pd = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d, lfsr = 8'h36;
  logic [7:0] cnt = 8'h00;
  logic [7:0] reg_rdata;
  logic       bclk_pin_out, bclk_pin_oe, general_pin_one_pin_out, general_pin_one_pin_oe;
  logic       dout_pin_out, dout_pin_oe, dac_modulator_clock, adc_modulator_clock;
  logic       dac_fs_tick, adc_fs_tick;
  logic [7:0] rw_list [7] = '{8'h0B, 8'h0C, 8'h12, 8'h13, 8'h0E, 8'h14, 8'h1A};
  int         fails = 0, n_checks = 0, nf, na, nb, ng, nd, polls;

  codec_clock_tree dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .mclk_pin(mclk_pin), .bclk_pin_in(bclk_pin_in),
    .general_pin_one_pin_in(general_pin_one_pin_in), .pll_clk(pll_clk),
    .dac_left_on(dac_left_on), .dac_right_on(dac_right_on), .adc_on(adc_on),
    .clkout_to_dout(clkout_to_dout), .bclk_pin_out(bclk_pin_out),
    .bclk_pin_oe(bclk_pin_oe), .general_pin_one_pin_out(general_pin_one_pin_out),
    .general_pin_one_pin_oe(general_pin_one_pin_oe), .dout_pin_out(dout_pin_out),
    .dout_pin_oe(dout_pin_oe), .dac_modulator_clock(dac_modulator_clock),
    .adc_modulator_clock(adc_modulator_clock), .dac_fs_tick(dac_fs_tick),
    .adc_fs_tick(adc_fs_tick));

  // ==========================================================
  // clock, source clocks, edge counters
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    #1 cnt++;
    mclk_pin = cnt[0];
    bclk_pin_in = cnt[1];
    general_pin_one_pin_in = cnt[2];
    pll_clk = cnt[3];
  end
  always @(posedge clk) begin
    pb <= bclk_pin_out;
    pg <= general_pin_one_pin_out;
    pd <= dout_pin_out;
    if (clr) begin
      nf <= 0;
      na <= 0;
      nb <= 0;
      ng <= 0;
      nd <= 0;
    end else begin
      nf <= nf + int'(dac_fs_tick);
      na <= na + int'(adc_fs_tick);
      nb <= nb + int'(bclk_pin_out & ~pb);
      ng <= ng + int'(general_pin_one_pin_out & ~pg);
      nd <= nd + int'(dout_pin_out & ~pd);
    end
  end

  // ==========================================================
  // tasks and expectation functions
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic near(input int c, input int e);
    return (c >= e - 1) && (c <= e + 1);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 reg_wr = 1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge clk);
    #1 reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1 reg_rd = 1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 0;
    d = reg_rdata;
  endtask
  task automatic window(input int n);
    #1 clr = 1;
    @(posedge clk);
    #1 clr = 0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task complete_run;
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 0;
    rd(8'h0B); `CHK("coarse rst", 8'h01, d)
    rd(8'h0E); `CHK("osr lo rst", 8'h80, d)
    rd(8'h14); `CHK("adc_oversample rst", 8'h80, d)
    wr(8'h25, 8'hFF);
    rd(8'h25); `CHK("status ro", 8'h00, d)
    wr(8'h03, 8'h5A);
    rd(8'h03); `CHK("unmapped", 8'h00, d)
    for (int i = 0; i < 14; i++) begin
      lfsr = nxt(lfsr);
      wr(rw_list[i % 7], lfsr);
      rd(rw_list[i % 7]); `CHK("rw", lfsr, d)
    end
    wr(8'h0B, 8'h84);
    rd(8'h0B); `CHK("coarse 84", 8'h84, d)
    // coarse 2, fine 1, both oversampling ratios 2
    wr(8'h0B, 8'h82);
    wr(8'h0C, 8'h81);
    wr(8'h0D, 8'h00);
    wr(8'h0E, 8'h02);
    wr(8'h12, 8'h02);
    wr(8'h13, 8'h01);
    wr(8'h14, 8'h02);
    wr(8'h1D, 8'h01);
    wr(8'h1E, 8'h02);
    wr(8'h1B, 8'h08);
    wr(8'h19, 8'h00);
    wr(8'h1A, 8'h84);
    for (int s = 3; s >= 0; s--) begin
      wr(8'h04, 8'(s));
      repeat (128) @(posedge clk);
      window(256);
      `CHK("dac fs", 1'b1, near(nf, 256 / (8 << s)))
    end
    `CHK("adc fs", 1'b1, near(na, nf))
    `CHK("bclk oe", 1'b1, bclk_pin_oe)
    `CHK("bclk rate", 1'b1, near(nb, 32))
    `CHK("gpio oe", 1'b1, general_pin_one_pin_oe)
    `CHK("clkout rate", 1'b1, near(ng, 32))
    // own ADC dividers; bit and general clocks from ADC modulator
    wr(8'h12, 8'h84);
    wr(8'h13, 8'h81);
    wr(8'h1D, 8'h03);
    wr(8'h19, 8'h07);
    repeat (64) @(posedge clk);
    window(256);
    `CHK("adc own fs", 1'b1, near(na, 16))
    `CHK("bclk adc", 1'b1, near(nb, 16))
    `CHK("clkout adc", 1'b1, near(ng, 8))
    wr(8'h13, 8'h01);
    wr(8'h12, 8'h02);
    wr(8'h1D, 8'h01);
    wr(8'h19, 8'h00);
    clkout_to_dout = 1;
    repeat (40) @(posedge clk);
    window(256);
    `CHK("dout oe", 1'b1, dout_pin_oe)
    `CHK("gpio off", 1'b0, general_pin_one_pin_oe)
    `CHK("dout rate", 1'b1, near(nd, 32))
    `CHK("gpio quiet", 0, ng)
    dac_left_on = 1;
    dac_right_on = 1;
    adc_on = 1;
    repeat (32) @(posedge clk);
    rd(8'h25); `CHK("dac up", 2'b11, {d[7], d[3]})
    rd(8'h24); `CHK("adc up", 1'b1, d[6])
    dac_left_on = 0;
    dac_right_on = 0;
    adc_on = 0;
    polls = 0;
    d = 8'hFF;
    while ((d[7] | d[3]) !== 1'b0 && polls < 200) begin
      rd(8'h25);
      polls++;
    end
    `CHK("left down", 1'b1, polls >= 40 && polls <= 90)
    rd(8'h24); `CHK("adc down", 1'b0, d[6])
    wr(8'h0C, 8'h01);
    wr(8'h0B, 8'h02);
    repeat (64) @(posedge clk);
    window(128);
    `CHK("stopped fs", 0, nf)
    `CHK("stopped mod", 1'b0, dac_modulator_clock)
    `CHK("stopped adc mod", 1'b0, adc_modulator_clock)
    complete_run();
  end
endmodule // codec_clock_divider_tree_tb_top
